// >>> hw/dmoc_pkg.sv
// Constants, register map and carrier types for the DMA operation control block
//
// Contract
// - Operation register is 32 bits; only the low four bits exist, upper read zero.
// - Operation register clears on reset and standby, holds in module standby.
// - Priority bit 0: channel 0 always beats channel 1 on simultaneous requests.
// - Priority bit 1: round robin, the top channel drops to lowest after each transfer.
// - Address error sets its flag; while set no channel may be enabled.
// - On address error the current unit finishes, then transfers stop.
// - Error flags clear only by writing 0 after reading 1; writing 1 does nothing.
// - NMI always sets its flag; while set all transfers stay disabled.
// - On NMI the unit in progress completes, then all transfers halt.
// - Channel enabled only with its enable, master enable, no end flag, no error flags.
// - Clearing the master enable aborts transfers on every channel.
// - Each accepted request moves one unit and decrements that channel's count by one.
// - Auto-request channels start by themselves once enabled.
// - Count reaching zero ends the channel; with interrupt enable, raise end interrupt.
// - Clearing a channel enable while operating aborts that channel.
// - Channels support single/dual address, burst/cycle-steal, auto/pin/peripheral requests.
package dmoc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_SOURCE = 8'h00;
  localparam logic [7:0] OFS_DEST = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL_OP = 8'h30;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OP_MASTER_ENABLE = 0;
  localparam int OP_NMI_SEEN = 1;
  localparam int OP_ADDR_ERROR = 2;
  localparam int OP_PRIO_ROTATE = 3;
  localparam int CC_CHANNEL_ENABLE = 0;
  localparam int CC_END_IRQ_ENABLE = 1;
  localparam int CC_TRANSFER_END = 2;
  localparam int CC_AUTO_REQUEST = 3;
  localparam int CC_PIN_REQUEST = 4;
  localparam int CC_BURST = 5;
  localparam int CC_SINGLE_ADDR = 6;
  localparam int CC_DEV_TO_MEM = 7;
  localparam int IS_END_CH0 = 0;
  localparam int IS_ADDR_ERROR = 2;
  localparam int IS_NMI = 3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int COUNT_W = 24;
  localparam logic [3:0] OP_RESET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } dmoc_state_type;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [COUNT_W-1:0] count;
    logic [7:0] ctrl;
  } dmoc_chan_type;

  // One transfer unit handed to the bus engine; held until done
  typedef struct packed {
    logic valid;
    logic ch;
    logic [31:0] src;
    logic [31:0] dst;
    logic single;
    logic dev_to_mem;
    logic burst;
  } dmoc_xfer_type;

  typedef struct packed {
    logic done;
    logic addr_err;
  } dmoc_xresp_type;

endpackage : dmoc_pkg

// >>> hw/dmoc_top.sv
// Two-channel DMA operation control: registers, enables, arbitration and unit sequencing
module dmoc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nmi_pin,
  input wire logic [1:0] ext_request_pin,
  input wire logic [1:0] periph_request,
  input wire logic standby,
  input wire logic module_standby,
  output dmoc_pkg::dmoc_xfer_type xfer,
  input wire dmoc_pkg::dmoc_xresp_type xresp,
  output logic [1:0] transfer_end_interrupt,
  output logic irq
);
  import dmoc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dmoc_chan_type [1:0] chan;
    logic [3:0] op;
    logic seen_ae;
    logic seen_nmi;
    logic top;
    dmoc_state_type state;
    logic cur;
    dmoc_xfer_type xfer;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic nmi_m;
    logic nmi_s;
    logic nmi_d;
    logic [1:0] ext_m;
    logic [1:0] ext_s;
  } dmoc_regs_type;

  dmoc_regs_type s_reg;
  dmoc_regs_type s_next;
  logic [1:0] en;
  logic [1:0] req;
  logic pick;
  logic nmi_rise;
  logic addr_ph;
  logic [7:0] a8;
  logic [7:0] wa;
  logic wch;
  logic rch;
  logic cont;
  logic [3:0] ev;

  // ----------------------------------------------------------------
  // Enables and arbitration
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      en[i] = s_reg.chan[i].ctrl[CC_CHANNEL_ENABLE] & s_reg.op[OP_MASTER_ENABLE]
            & ~s_reg.chan[i].ctrl[CC_TRANSFER_END]
            & ~s_reg.op[OP_NMI_SEEN] & ~s_reg.op[OP_ADDR_ERROR];
      req[i] = en[i] & (s_reg.chan[i].ctrl[CC_AUTO_REQUEST]
             | (s_reg.chan[i].ctrl[CC_PIN_REQUEST] ? s_reg.ext_s[i]
                                                   : periph_request[i]));
    end
    if (req[0] && req[1]) begin
      pick = s_reg.op[OP_PRIO_ROTATE] ? s_reg.top : 1'b0;
    end else begin
      pick = req[1] & ~req[0];
    end
  end

  assign nmi_rise = s_reg.nmi_s & ~s_reg.nmi_d;
  assign addr_ph = hsel & htrans[1] & hready;
  assign a8 = haddr[7:0];
  assign wa = s_reg.wr_addr;
  assign wch = wa[4];
  assign rch = a8[4];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    cont = 1'b0;
    ev = 4'h0;
    // Pin inputs pass two flops before use
    s_next.nmi_m = nmi_pin;
    s_next.nmi_s = s_reg.nmi_m;
    s_next.nmi_d = s_reg.nmi_s;
    s_next.ext_m = ext_request_pin;
    s_next.ext_s = s_reg.ext_m;

    // Register write, data phase
    s_next.wr_pend = addr_ph & hwrite;
    if (addr_ph) begin
      s_next.wr_addr = a8;
    end
    if (s_reg.wr_pend) begin
      if (wa < OFS_GLOBAL_OP) begin
        unique case ({4'h0, wa[3:0]})
          OFS_SOURCE: s_next.chan[wch].src = hwdata;
          OFS_DEST: s_next.chan[wch].dst = hwdata;
          OFS_COUNT: s_next.chan[wch].count = hwdata[COUNT_W-1:0];
          default: begin
            // End flag accepts only a clearing write
            s_next.chan[wch].ctrl = {hwdata[7:3], s_reg.chan[wch].ctrl[CC_TRANSFER_END]
                                    & hwdata[CC_TRANSFER_END], hwdata[1:0]};
          end
        endcase
      end else if (wa == OFS_GLOBAL_OP) begin
        s_next.op[OP_MASTER_ENABLE] = hwdata[OP_MASTER_ENABLE];
        s_next.op[OP_PRIO_ROTATE] = hwdata[OP_PRIO_ROTATE];
        if (!hwdata[OP_ADDR_ERROR] && s_reg.seen_ae) begin
          s_next.op[OP_ADDR_ERROR] = 1'b0;
          s_next.seen_ae = 1'b0;
        end
        if (!hwdata[OP_NMI_SEEN] && s_reg.seen_nmi) begin
          s_next.op[OP_NMI_SEEN] = 1'b0;
          s_next.seen_nmi = 1'b0;
        end
      end else if (wa == OFS_IRQ_STATUS) begin
        s_next.irq_stat = s_reg.irq_stat & ~hwdata[3:0];
      end else if (wa == OFS_IRQ_MASK) begin
        s_next.irq_mask = hwdata[3:0];
      end
    end

    // Register read, data captured at the address phase
    if (addr_ph && !hwrite) begin
      s_next.rdata = 32'h00000000;
      if (a8 < OFS_GLOBAL_OP) begin
        unique case ({4'h0, a8[3:0]})
          OFS_SOURCE: s_next.rdata = s_reg.chan[rch].src;
          OFS_DEST: s_next.rdata = s_reg.chan[rch].dst;
          OFS_COUNT: s_next.rdata = {8'h00, s_reg.chan[rch].count};
          default: s_next.rdata = {24'h000000, s_reg.chan[rch].ctrl};
        endcase
      end else if (a8 == OFS_GLOBAL_OP) begin
        s_next.rdata = {28'h0000000, s_reg.op};
        // A flag seen as one arms its clearing write
        s_next.seen_ae = s_next.seen_ae | s_reg.op[OP_ADDR_ERROR];
        s_next.seen_nmi = s_next.seen_nmi | s_reg.op[OP_NMI_SEEN];
      end else if (a8 == OFS_IRQ_STATUS) begin
        s_next.rdata = {28'h0000000, s_reg.irq_stat};
      end else if (a8 == OFS_IRQ_MASK) begin
        s_next.rdata = {28'h0000000, s_reg.irq_mask};
      end
    end

    // Transfer sequencing
    unique case (s_reg.state)
      ST_IDLE: begin
        if (|req && !module_standby) begin
          s_next.state = ST_BUSY;
          s_next.cur = pick;
          s_next.xfer = {1'b1, pick, s_reg.chan[pick].src, s_reg.chan[pick].dst,
                         s_reg.chan[pick].ctrl[CC_SINGLE_ADDR],
                         s_reg.chan[pick].ctrl[CC_DEV_TO_MEM],
                         s_reg.chan[pick].ctrl[CC_BURST]};
        end
      end
      ST_BUSY: begin
        // The unit in flight completes unless standby drops it; aborts only stop the next one
        if (xresp.done) begin
          s_next.chan[s_reg.cur].count = s_reg.chan[s_reg.cur].count - COUNT_ONE;
          s_next.top = ~s_reg.cur;
          if (s_reg.chan[s_reg.cur].count == COUNT_ONE) begin
            s_next.chan[s_reg.cur].ctrl[CC_TRANSFER_END] = 1'b1;
            ev[IS_END_CH0 + {31'h0, s_reg.cur}] = 1'b1;
          end
          if (xresp.addr_err) begin
            s_next.op[OP_ADDR_ERROR] = 1'b1;
            ev[IS_ADDR_ERROR] = 1'b1;
          end
          // Burst keeps the channel, cycle-steal re-arbitrates
          cont = s_reg.chan[s_reg.cur].ctrl[CC_BURST] & req[s_reg.cur] & ~module_standby
               & (s_reg.chan[s_reg.cur].count != COUNT_ONE) & ~xresp.addr_err
               & ~nmi_rise;
          s_next.xfer.valid = cont;
          s_next.state = cont ? ST_BUSY : ST_IDLE;
        end
      end
    endcase

    if (nmi_rise) begin
      s_next.op[OP_NMI_SEEN] = 1'b1;
      ev[IS_NMI] = 1'b1;
    end
    // Hardware events win over a clearing write in the same cycle
    s_next.irq_stat = s_next.irq_stat | ev;

    if (standby) begin
      s_next.op = OP_RESET;
      s_next.seen_ae = 1'b0;
      s_next.seen_nmi = 1'b0;
      s_next.top = 1'b0;
      s_next.state = ST_IDLE;
      s_next.xfer.valid = 1'b0;
      s_next.irq_stat = IRQ_RESET;
      for (int i = 0; i < 2; i++) begin
        s_next.chan[i].ctrl = CTRL_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign xfer = s_reg.xfer;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
  for (genvar g = 0; g < 2; g++) begin : g_end
    assign transfer_end_interrupt[g] = s_reg.chan[g].ctrl[CC_TRANSFER_END]
                                     & s_reg.chan[g].ctrl[CC_END_IRQ_ENABLE];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fixed_prio: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_IDLE && &req && !s_reg.op[OP_PRIO_ROTATE] && !module_standby
     && !standby) |=> (xfer.valid && xfer.ch == 1'b0))
    else $error("fixed priority did not pick channel 0");

  a_rr_rotate: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_BUSY && xresp.done && !standby) |=> (s_reg.top != $past(s_reg.cur)))
    else $error("top priority did not move after a transfer");

  a_flag_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_IDLE && (s_reg.op[OP_ADDR_ERROR] || s_reg.op[OP_NMI_SEEN]))
    |=> !xfer.valid)
    else $error("transfer started while an error flag was set");

  a_unit_held: assert property (@(posedge hclk) disable iff (!hresetn)
    (xfer.valid && !xresp.done && !standby) |=> (xfer.valid && $stable(xfer.ch)))
    else $error("unit dropped before completion");

  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(s_reg.op[OP_ADDR_ERROR]) && !$past(standby)) |-> $past(s_reg.seen_ae))
    else $error("address error flag cleared without a prior read");

  a_nmi_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (nmi_rise && !standby) |=> s_reg.op[OP_NMI_SEEN])
    else $error("nmi flag not set");

  a_no_master: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_IDLE && !s_reg.op[OP_MASTER_ENABLE]) |=> s_reg.state == ST_IDLE)
    else $error("transfer started with master enable clear");

  a_count_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_BUSY && xresp.done && !standby
     && s_reg.chan[s_reg.cur].count == COUNT_ONE)
    |=> (s_reg.chan[$past(s_reg.cur)].ctrl[CC_TRANSFER_END] && !xfer.valid))
    else $error("end flag not set at count zero");

  a_auto_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_IDLE && en[0] && s_reg.chan[0].ctrl[CC_AUTO_REQUEST]
     && !module_standby && !standby) |=> xfer.valid)
    else $error("auto request did not start");

  a_standby_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    standby |=> (s_reg.op == OP_RESET))
    else $error("standby did not clear the operation register");

endmodule // dmoc_top

// >>> tb/dmoc_bus_model.sv
// Bus-side partner model answering each transfer unit after a fixed delay
module dmoc_bus_model
  import dmoc_pkg::*;
#(
  parameter int DLY = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire dmoc_pkg::dmoc_xfer_type xfer,
  input wire logic err_req,
  output dmoc_pkg::dmoc_xresp_type xresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  // ----------------------------------------------------------------
  // Unit answer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
    end else if (!xfer.valid || xresp.done) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // One pulse per held unit, never while idle
  assign xresp.done = xfer.valid && (cnt_reg == DLY[3:0]);
  // Error only when a scenario asks for it
  assign xresp.addr_err = xresp.done && err_req;
endmodule // dmoc_bus_model

// >>> tb/tb_top.sv
// Self-checking bench for the DMA operation control block
module tb_top;
  import dmoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic nmi_pin = 1'b0;
  logic standby = 1'b0;
  logic module_standby = 1'b0;
  logic err_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [1:0] tei;
  logic [3:0] seq = 4'h0;
  dmoc_xfer_type xfer;
  dmoc_xresp_type xresp;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [7:0] OP = OFS_GLOBAL_OP;
  always #5 hclk = ~hclk;
  dmoc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nmi_pin(nmi_pin), .ext_request_pin(2'h0), .periph_request(2'h0),
    .standby(standby), .module_standby(module_standby), .xfer(xfer),
    .xresp(xresp), .transfer_end_interrupt(tei), .irq(irq));
  dmoc_bus_model #(.DLY(2)) PARTNER (.hclk(hclk), .hresetn(hresetn),
    .xfer(xfer), .err_req(err_req), .xresp(xresp));
  // ----------------------------------------------------------------
  // Unit order log and hang guard
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (xfer.valid && xresp.done) seq <= {seq[2:0], xfer.ch};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic setch(input logic [7:0] ch, input logic [23:0] n, input logic [7:0] c);
    wr(OFS_CH_STRIDE * ch + OFS_COUNT, {8'h0, n});
    wr(OFS_CH_STRIDE * ch + OFS_CONTROL, {24'h0, c});
  endtask
  task automatic wait_end(input logic [1:0] m);
    for (int i = 0; i < 300 && (tei & m) !== m; i++) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdc(OP, 32'h0);
    wr(OP, 32'h9);
    rdc(OP, 32'h9);
    module_standby <= 1'b1;
    idle(2);
    module_standby <= 1'b0;
    rdc(OP, 32'h9);
    standby <= 1'b1;
    idle(1);
    standby <= 1'b0;
    rdc(OP, 32'h0);
    rdc(8'h3C, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Two units per channel; the log shows the grant order
  task automatic t_prio(input logic rot, input logic [3:0] e);
    setch(8'h0, 24'h2, 8'h0B);
    setch(8'h1, 24'h2, 8'h0B);
    wr(OP, {28'h0, rot, 3'b001});
    wait_end(2'h3);
    chk({28'h0, seq}, {28'h0, e});
    rdc(OFS_COUNT, 32'h0);
    rdc(OFS_CONTROL, 32'h0F);
    chk({30'h0, tei}, 32'h3);
    wr(OFS_IRQ_MASK, 32'h1);
    rdc(OFS_IRQ_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h3);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    setch(8'h0, 24'h0, 8'h00);
    setch(8'h1, 24'h0, 8'h00);
    wr(OP, 32'h0);
  endtask
  task automatic t_nmi();
    nmi_pin <= 1'b1;
    idle(4);
    nmi_pin <= 1'b0;
    setch(8'h0, 24'h1, 8'h09);
    wr(OP, 32'h1);
    idle(20);
    rdc(OFS_COUNT, 32'h1);
    // Clear write without a prior read of the flag must not count
    wr(OP, 32'h1);
    rdc(OP, 32'h3);
    wr(OP, 32'h1);
    wait_end(2'h1);
    rdc(OP, 32'h1);
    rdc(OFS_COUNT, 32'h0);
    setch(8'h0, 24'h0, 8'h00);
    wr(OP, 32'h0);
  endtask
  task automatic t_aerr();
    err_req <= 1'b1;
    setch(8'h0, 24'h3, 8'h09);
    wr(OP, 32'h1);
    idle(30);
    rdc(OFS_COUNT, 32'h2);
    rdc(OP, 32'h5);
    err_req <= 1'b0;
    wr(OP, 32'h0);
    setch(8'h0, 24'h0, 8'h00);
  endtask
  task automatic t_abort();
    setch(8'h0, 24'h100, 8'h09);
    wr(OP, 32'h1);
    idle(10);
    wr(OP, 32'h0);
    idle(8);
    chk({31'h0, xfer.valid}, 32'h0);
    wr(OP, 32'h1);
    idle(10);
    wr(OFS_CONTROL, 32'h0);
    idle(8);
    chk({31'h0, xfer.valid}, 32'h0);
    wr(OP, 32'h0);
  endtask
  initial begin
    idle(20);
    hresetn <= 1'b1;
    idle(1);
    t_regs();
    t_prio(1'b0, 4'h3);
    t_prio(1'b1, 4'h5);
    t_nmi();
    t_aerr();
    t_abort();
    end_of_test();
  end
endmodule // tb_top
